// ### tsl_pkg.sv
// Constants and types for the torque reference and speed limit block
package tsl_pkg;

    localparam logic [7:0] TSL_ADDR_CTRL = 8'h00;
    localparam logic [7:0] TSL_ADDR_TQ_GAIN = 8'h04;
    localparam logic [7:0] TSL_ADDR_SPD_LIM = 8'h08;
    localparam logic [7:0] TSL_ADDR_SPD_GAIN = 8'h0C;
    localparam logic [7:0] TSL_ADDR_OFFSET = 8'h10;
    localparam logic [7:0] TSL_ADDR_STATUS = 8'h14;
    localparam logic [7:0] TSL_ADDR_TQ_MON = 8'h18;

    localparam int TSL_CTRL_START_BIT = 0;
    localparam int TSL_CTRL_SEL_BIT = 1;
    localparam int TSL_CTRL_TQ_MODE_BIT = 2;

    localparam logic [6:0] TSL_TQ_GAIN_RST = 7'h1E;
    localparam logic [6:0] TSL_TQ_GAIN_MIN = 7'h0A;
    localparam logic [6:0] TSL_TQ_GAIN_MAX = 7'h64;
    localparam logic [12:0] TSL_SPD_LIM_RST = 13'h05DC;
    localparam logic [12:0] TSL_SPD_LIM_MAX = 13'h1770;
    localparam logic [11:0] TSL_SPD_GAIN_RST = 12'h096;
    localparam logic [11:0] TSL_SPD_GAIN_MAX = 12'hBB8;

    // Per-mille of rated torque per (mV / gain)
    localparam logic [3:0] TSL_TQ_SCALE = 4'hA;
    localparam int TSL_MV_PER_V = 1000;
    localparam int TSL_OFS_LOG2 = 4;
    localparam logic [3:0] TSL_OFS_LAST = 4'hF;

    typedef struct packed {
        logic spd_limiting;
        logic ofs_refused;
        logic ofs_done;
        logic ofs_busy;
    } tsl_status_t;

    typedef enum logic {
        TSL_OFS_IDLE,
        TSL_OFS_MEAS
    } tsl_ofs_state_t;

endpackage

// ### tsl_divider.sv
// Sequential restoring divider for the torque scaling path
`timescale 1ns/1ps
module tsl_divider #(
    parameter int W = 20
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire logic [W-1:0] i_num,
    input wire logic [W-1:0] i_den,
    output logic o_busy,
    output logic o_done,
    output logic [W-1:0] o_quot
);
    logic [W-1:0] num_q;
    logic [W-1:0] den_q;
    logic [W:0] rem_q;
    logic [$clog2(W+1)-1:0] cnt_q;
    logic busy_q;
    logic done_q;
    logic [W:0] trial;

    assign trial = {rem_q[W-1:0], num_q[W-1]} - {1'b0, den_q};

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            num_q <= '0;
            den_q <= '0;
            rem_q <= '0;
            cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (i_start && !busy_q) begin
                num_q <= i_num;
                den_q <= i_den;
                rem_q <= '0;
                cnt_q <= '0;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (trial[W]) begin
                    rem_q <= {rem_q[W-1:0], num_q[W-1]};
                    num_q <= {num_q[W-2:0], 1'b0};
                end else begin
                    rem_q <= trial;
                    num_q <= {num_q[W-2:0], 1'b1};
                end
                cnt_q <= cnt_q + 1'b1;
                if (cnt_q == ($clog2(W+1))'(W - 1)) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

    assign o_busy = busy_q;
    assign o_done = done_q;
    assign o_quot = num_q;
endmodule

// ### tsl_torque_ref.sv
// Torque reference scaling, offset correction and torque-mode speed limiter with APB registers
`timescale 1ns/1ps
module tsl_torque_ref
    import tsl_pkg::*;
#(
    parameter logic [12:0] MOTOR_MAX_RPM = 13'h0BB8,
    parameter logic signed [15:0] OFFSET_MAX_MV = 16'sh0400
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [15:0] i_torque_ref_mv,
    input wire logic signed [15:0] i_speed_ref_mv,
    input wire logic i_servo_on,
    input wire logic signed [15:0] i_motor_speed_rpm,
    output logic signed [15:0] o_torque_cmd,
    output logic signed [15:0] o_torque_monitor,
    output logic o_speed_limiting
);
    localparam int DW = 20;

    logic signed [15:0] tq_sync1_q;
    logic signed [15:0] tq_sync2_q;
    logic signed [15:0] vs_sync1_q;
    logic signed [15:0] vs_sync2_q;
    logic servo_sync1_q;
    logic servo_sync2_q;

    logic [6:0] tq_gain_q;
    logic [12:0] spd_lim_q;
    logic [11:0] spd_gain_q;
    logic signed [15:0] offset_q;
    logic limit_sel_q;
    logic tq_mode_q;
    logic ofs_done_q;
    logic ofs_refused_q;
    tsl_ofs_state_t ofs_state_q;
    logic [3:0] ofs_cnt_q;
    logic signed [19:0] ofs_sum_q;
    logic [31:0] prdata_q;

    logic wr_en;
    logic rd_setup;
    logic start_req;
    logic start_ok;
    logic clr_done;
    logic clr_refused;
    tsl_status_t status;

    logic signed [16:0] corrected;
    logic [DW-1:0] div_num;
    logic div_busy;
    logic div_done;
    logic [DW-1:0] div_quot;
    logic neg_q;
    logic signed [15:0] cmd_raw_q;
    logic signed [15:0] cmd_q;
    logic signed [15:0] mon_q;
    logic limiting_q;

    logic [12:0] int_lim;
    logic [27:0] ext_prod;
    logic [12:0] ext_lim;
    logic [12:0] act_lim;
    logic over_fwd;
    logic over_rev;

    function automatic logic addr_valid(input logic [7:0] a);
        return a == TSL_ADDR_CTRL || a == TSL_ADDR_TQ_GAIN || a == TSL_ADDR_SPD_LIM ||
               a == TSL_ADDR_SPD_GAIN || a == TSL_ADDR_OFFSET || a == TSL_ADDR_STATUS ||
               a == TSL_ADDR_TQ_MON;
    endfunction

    function automatic logic [15:0] mag16(input logic signed [15:0] v);
        return v[15] ? 16'(-v) : 16'(v);
    endfunction

    function automatic logic [12:0] min13(input logic [12:0] a, input logic [12:0] b);
        return (a < b) ? a : b;
    endfunction

    // Two-flop synchronisers for the torque reference, speed reference and servo enable inputs (motor speed is used unsynchronised)
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tq_sync1_q <= '0;
            tq_sync2_q <= '0;
            vs_sync1_q <= '0;
            vs_sync2_q <= '0;
            servo_sync1_q <= 1'b0;
            servo_sync2_q <= 1'b0;
        end else begin
            tq_sync1_q <= i_torque_ref_mv;
            tq_sync2_q <= tq_sync1_q;
            vs_sync1_q <= i_speed_ref_mv;
            vs_sync2_q <= vs_sync1_q;
            servo_sync1_q <= i_servo_on;
            servo_sync2_q <= servo_sync1_q;
        end
    end

    // Bus decode, zero wait states
    assign wr_en = psel && penable && pwrite && addr_valid(paddr);
    assign rd_setup = psel && !penable;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_valid(paddr);
    assign prdata = prdata_q;
    assign start_req = wr_en && paddr == TSL_ADDR_CTRL && pwdata[TSL_CTRL_START_BIT];
    assign start_ok = start_req && !servo_sync2_q && ofs_state_q == TSL_OFS_IDLE;
    assign clr_done = wr_en && paddr == TSL_ADDR_STATUS && pwdata[1];
    assign clr_refused = wr_en && paddr == TSL_ADDR_STATUS && pwdata[2];

    // Control bits
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            limit_sel_q <= 1'b0;
            tq_mode_q <= 1'b0;
        end else if (wr_en && paddr == TSL_ADDR_CTRL) begin
            limit_sel_q <= pwdata[TSL_CTRL_SEL_BIT];
            tq_mode_q <= pwdata[TSL_CTRL_TQ_MODE_BIT];
        end
    end

    // Torque gain, clamped to its range
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tq_gain_q <= TSL_TQ_GAIN_RST;
        end else if (wr_en && paddr == TSL_ADDR_TQ_GAIN) begin
            if (pwdata < 32'(TSL_TQ_GAIN_MIN)) begin
                tq_gain_q <= TSL_TQ_GAIN_MIN;
            end else if (pwdata > 32'(TSL_TQ_GAIN_MAX)) begin
                tq_gain_q <= TSL_TQ_GAIN_MAX;
            end else begin
                tq_gain_q <= pwdata[6:0];
            end
        end
    end

    // Speed limit and speed gain, both take effect at once
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            spd_lim_q <= TSL_SPD_LIM_RST;
            spd_gain_q <= TSL_SPD_GAIN_RST;
        end else if (wr_en) begin
            if (paddr == TSL_ADDR_SPD_LIM) begin
                spd_lim_q <= (pwdata > 32'(TSL_SPD_LIM_MAX)) ? TSL_SPD_LIM_MAX : pwdata[12:0];
            end
            if (paddr == TSL_ADDR_SPD_GAIN) begin
                spd_gain_q <= (pwdata > 32'(TSL_SPD_GAIN_MAX)) ? TSL_SPD_GAIN_MAX : pwdata[11:0];
            end
        end
    end

    // Offset measurement state
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ofs_state_q <= TSL_OFS_IDLE;
            ofs_cnt_q <= '0;
            ofs_sum_q <= '0;
        end else begin
            unique case (ofs_state_q)
                TSL_OFS_IDLE: begin
                    if (start_ok) begin
                        ofs_state_q <= TSL_OFS_MEAS;
                        ofs_cnt_q <= '0;
                        ofs_sum_q <= '0;
                    end
                end
                TSL_OFS_MEAS: begin
                    ofs_sum_q <= ofs_sum_q + 20'(tq_sync2_q);
                    ofs_cnt_q <= ofs_cnt_q + 4'h1;
                    if (ofs_cnt_q == TSL_OFS_LAST) begin
                        ofs_state_q <= TSL_OFS_IDLE;
                    end
                end
            endcase
        end
    end

    // Stored offset: measured result, or direct entry clamped to OFFSET_MAX_MV
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            offset_q <= '0;
        end else if (ofs_state_q == TSL_OFS_MEAS && ofs_cnt_q == TSL_OFS_LAST) begin
            offset_q <= 16'((ofs_sum_q + 20'(tq_sync2_q)) >>> TSL_OFS_LOG2);
        end else if (wr_en && paddr == TSL_ADDR_OFFSET && ofs_state_q == TSL_OFS_IDLE) begin
            if ($signed(pwdata[15:0]) > OFFSET_MAX_MV) begin
                offset_q <= OFFSET_MAX_MV;
            end else if ($signed(pwdata[15:0]) < -OFFSET_MAX_MV) begin
                offset_q <= -OFFSET_MAX_MV;
            end else begin
                offset_q <= pwdata[15:0];
            end
        end
    end

    // Sticky status, a set beats a clear in the same cycle
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ofs_done_q <= 1'b0;
            ofs_refused_q <= 1'b0;
        end else begin
            if (ofs_state_q == TSL_OFS_MEAS && ofs_cnt_q == TSL_OFS_LAST) begin
                ofs_done_q <= 1'b1;
            end else if (clr_done) begin
                ofs_done_q <= 1'b0;
            end
            if (start_req && servo_sync2_q) begin
                ofs_refused_q <= 1'b1;
            end else if (clr_refused) begin
                ofs_refused_q <= 1'b0;
            end
        end
    end

    assign status = '{spd_limiting: limiting_q, ofs_refused: ofs_refused_q, ofs_done: ofs_done_q,
                      ofs_busy: ofs_state_q == TSL_OFS_MEAS};

    // Read data captured in the setup phase
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            prdata_q <= '0;
        end else if (rd_setup) begin
            unique case (paddr)
                TSL_ADDR_CTRL: prdata_q <= {29'h0, tq_mode_q, limit_sel_q, 1'b0};
                TSL_ADDR_TQ_GAIN: prdata_q <= {25'h0, tq_gain_q};
                TSL_ADDR_SPD_LIM: prdata_q <= {19'h0, spd_lim_q};
                TSL_ADDR_SPD_GAIN: prdata_q <= {20'h0, spd_gain_q};
                TSL_ADDR_OFFSET: prdata_q <= {{16{offset_q[15]}}, offset_q};
                TSL_ADDR_STATUS: prdata_q <= {28'h0, status};
                TSL_ADDR_TQ_MON: prdata_q <= {{16{mon_q[15]}}, mon_q};
                default: prdata_q <= '0;
            endcase
        end
    end

    // Offset-corrected reference magnitude scaled for the gain division
    assign corrected = 17'(tq_sync2_q) - 17'(offset_q);
    assign div_num = 20'(corrected[16] ? 17'(-corrected) : corrected) * 20'(TSL_TQ_SCALE);

    tsl_divider #(
        .W(DW)
    ) u_div (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_start(!div_busy && !div_done),
        .i_num(div_num),
        .i_den(20'(tq_gain_q)),
        .o_busy(div_busy),
        .o_done(div_done),
        .o_quot(div_quot)
    );

    // Direction captured with each division
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            neg_q <= 1'b0;
        end else if (!div_busy && !div_done) begin
            neg_q <= corrected[16];
        end
    end

    // Signed torque command in per-mille of rated torque
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cmd_raw_q <= '0;
        end else if (div_done) begin
            if (div_quot > 20'h07FFF) begin
                cmd_raw_q <= neg_q ? -16'sh7FFF : 16'sh7FFF;
            end else begin
                cmd_raw_q <= neg_q ? -$signed(div_quot[15:0]) : $signed(div_quot[15:0]);
            end
        end
    end

    // Active speed limit
    assign int_lim = min13(spd_lim_q, MOTOR_MAX_RPM);
    assign ext_prod = 28'(mag16(vs_sync2_q)) * 28'(spd_gain_q);
    assign ext_lim = (ext_prod / 28'(TSL_MV_PER_V) > 28'(TSL_SPD_LIM_MAX)) ? TSL_SPD_LIM_MAX
                     : 13'(ext_prod / 28'(TSL_MV_PER_V));
    assign act_lim = limit_sel_q ? min13(ext_lim, int_lim) : int_lim;
    assign over_fwd = i_motor_speed_rpm > $signed({3'b000, act_lim}) && cmd_raw_q > 16'sh0000;
    assign over_rev = i_motor_speed_rpm < -$signed({3'b000, act_lim}) && cmd_raw_q < 16'sh0000;

    // Speed limiter and monitor outputs
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cmd_q <= '0;
            limiting_q <= 1'b0;
            mon_q <= '0;
        end else begin
            if (tq_mode_q && (over_fwd || over_rev)) begin
                cmd_q <= '0;
                limiting_q <= 1'b1;
            end else begin
                cmd_q <= cmd_raw_q;
                limiting_q <= 1'b0;
            end
            mon_q <= cmd_q;
        end
    end

    assign o_torque_cmd = cmd_q;
    assign o_torque_monitor = mon_q;
    assign o_speed_limiting = limiting_q;

    sequence s_meas_run;
        (ofs_state_q == TSL_OFS_MEAS && ofs_cnt_q == 4'h0) ##15
        (ofs_state_q == TSL_OFS_MEAS && ofs_cnt_q == TSL_OFS_LAST) ##1 (ofs_state_q == TSL_OFS_IDLE);
    endsequence

    sequence s_stored;
        ofs_done_q && !status.ofs_busy;
    endsequence

    a_gain_range: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        tq_gain_q >= TSL_TQ_GAIN_MIN && tq_gain_q <= TSL_TQ_GAIN_MAX)
        else $error("torque gain out of range");

    a_spd_lim_range: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        wr_en && paddr == TSL_ADDR_SPD_LIM && pwdata <= 32'(TSL_SPD_LIM_MAX) |=> spd_lim_q == $past(pwdata[12:0]))
        else $error("speed limit write not applied at once");

    a_spd_gain_range: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        spd_gain_q <= TSL_SPD_GAIN_MAX)
        else $error("speed gain out of range");

    a_ofs_refused: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        start_req && servo_sync2_q |=> ofs_refused_q && ofs_state_q == TSL_OFS_IDLE)
        else $error("offset measurement ran with servo on");

    a_ofs_meas_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        start_ok |=> s_meas_run ##1 s_stored)
        else $error("offset measurement length wrong");

    a_limit_fwd: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        tq_mode_q && over_fwd |=> cmd_q == 16'sh0000 && o_speed_limiting)
        else $error("forward overspeed not limited");

    a_int_only: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !limit_sel_q && tq_mode_q && cmd_raw_q > 16'sh0000 && i_motor_speed_rpm <= $signed({3'b000, int_lim})
        |=> cmd_q == $past(cmd_raw_q))
        else $error("external limit used with select 0");

    a_ext_min: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        limit_sel_q && tq_mode_q && cmd_raw_q > 16'sh0000 && i_motor_speed_rpm > $signed({3'b000, ext_lim})
        |=> cmd_q == 16'sh0000)
        else $error("external limit not applied");

    a_motor_max: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        tq_mode_q && cmd_raw_q < 16'sh0000 && i_motor_speed_rpm < -$signed({3'b000, MOTOR_MAX_RPM})
        |=> cmd_q == 16'sh0000)
        else $error("motor maximum speed not applied");

    a_monitor_follow: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        ##1 o_torque_monitor == $past(o_torque_cmd))
        else $error("monitor does not follow torque command");

    a_cmd_sign: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        div_done && div_quot != '0 |=> (cmd_raw_q < 16'sh0000) == $past(neg_q))
        else $error("torque direction wrong");
endmodule

// ### tsl_host_model.sv
// Host controller model driving the analog references and the servo enable
`timescale 1ns/1ps
module tsl_host_model (
    input wire logic i_clk,
    output logic signed [15:0] o_torque_ref_mv,
    output logic signed [15:0] o_speed_ref_mv,
    output logic o_servo_on
);
    initial begin
        o_torque_ref_mv = 16'sh0000;
        o_speed_ref_mv = 16'sh0000;
        o_servo_on = 1'b0;
    end
    // New levels land just after a rising edge and then stand
    task automatic drive(input logic signed [15:0] tq, input logic signed [15:0] sp, input logic on);
        @(posedge i_clk);
        o_torque_ref_mv <= tq;
        o_speed_ref_mv <= sp;
        o_servo_on <= on;
    endtask
endmodule

// ### test_torque_reference_speed_limit.sv
// Self-checking testbench for the torque reference and speed limit block
`timescale 1ns/1ps
module test_torque_reference_speed_limit;
    import tsl_pkg::*;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic signed [15:0] tq_mv;
    logic signed [15:0] sp_mv;
    logic servo_on;
    logic signed [15:0] spd = 16'sh0000;
    logic signed [15:0] o_torque_cmd;
    logic signed [15:0] o_torque_monitor;
    logic o_speed_limiting;
    int failures = 0;
    int compares = 0;
    logic [31:0] d;
    logic e;

    always #2.5 i_clk = ~i_clk;

    tsl_host_model u_host (.i_clk(i_clk), .o_torque_ref_mv(tq_mv), .o_speed_ref_mv(sp_mv), .o_servo_on(servo_on));

    tsl_torque_ref u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .i_torque_ref_mv(tq_mv), .i_speed_ref_mv(sp_mv), .i_servo_on(servo_on), .i_motor_speed_rpm(spd),
        .o_torque_cmd(o_torque_cmd), .o_torque_monitor(o_torque_monitor), .o_speed_limiting(o_speed_limiting));

    task automatic summarize();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] ex, input logic [31:0] seen);
        compares++;
        if (seen !== ex) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, ex, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
        output logic err);
        int n;
        @(posedge i_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge i_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] r;
        logic x;
        apb(1'b1, a, wd, r, x);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string name);
        logic [31:0] r;
        logic x;
        apb(1'b0, a, 32'h0, r, x);
        chk(name, ex, r);
    endtask

    function automatic logic signed [15:0] exp_cmd(input int v, input int g);
        int m;
        m = (v < 0 ? -v : v) * 10 / g;
        if (m > 32767) m = 32767;
        return v < 0 ? 16'(-m) : 16'(m);
    endfunction

    // Waits for the command to settle, then checks command, monitor copy and limiter flag
    task automatic wait_cmd(input logic signed [15:0] ex, input logic lim);
        int n;
        n = 0;
        repeat (4) @(posedge i_clk);
        #1;
        while (o_torque_cmd !== ex && n < 300) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n >= 300) begin
            failures++;
            summarize();
        end
        repeat (2) @(posedge i_clk);
        #1;
        chk("torque_cmd", {{16{ex[15]}}, ex}, {{16{o_torque_cmd[15]}}, o_torque_cmd});
        chk("torque_monitor", {{16{ex[15]}}, ex}, {{16{o_torque_monitor[15]}}, o_torque_monitor});
        chk("speed_limiting", {31'h0, lim}, {31'h0, o_speed_limiting});
    endtask

    task automatic run(input logic signed [15:0] tq, input logic signed [15:0] sp, input logic signed [15:0] s,
        input logic signed [15:0] ex, input logic lim);
        u_host.drive(tq, sp, 1'b0);
        spd <= s;
        wait_cmd(ex, lim);
    endtask

    initial begin
        #400000;
        failures++;
        summarize();
    end

    initial begin
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(TSL_ADDR_CTRL, 32'h0, "ctrl_rst");
        rd(TSL_ADDR_TQ_GAIN, 32'd30, "tq_gain_rst");
        rd(TSL_ADDR_SPD_LIM, 32'd1500, "spd_lim_rst");
        rd(TSL_ADDR_SPD_GAIN, 32'd150, "spd_gain_rst");
        rd(TSL_ADDR_OFFSET, 32'h0, "offset_rst");
        rd(TSL_ADDR_STATUS, 32'h0, "status_rst");
        apb(1'b0, 8'h40, 32'h0, d, e);
        chk("unmapped_rdata", 32'h0, d);
        chk("unmapped_err", 32'h1, {31'h0, e});
        wr(TSL_ADDR_TQ_GAIN, 32'd5);
        rd(TSL_ADDR_TQ_GAIN, 32'd10, "tq_gain_low");
        wr(TSL_ADDR_TQ_GAIN, 32'd200);
        rd(TSL_ADDR_TQ_GAIN, 32'd100, "tq_gain_high");
        wr(TSL_ADDR_SPD_LIM, 32'd7000);
        rd(TSL_ADDR_SPD_LIM, 32'd6000, "spd_lim_high");
        wr(TSL_ADDR_SPD_GAIN, 32'd4000);
        rd(TSL_ADDR_SPD_GAIN, 32'd3000, "spd_gain_high");
        wr(TSL_ADDR_TQ_GAIN, 32'd30);
        wr(TSL_ADDR_SPD_LIM, 32'd1500);
        wr(TSL_ADDR_SPD_GAIN, 32'd150);
        run(16'sd3000, 16'sd0, 16'sd0, exp_cmd(3000, 30), 1'b0);
        rd(TSL_ADDR_TQ_MON, 32'd1000, "tq_monitor_reg");
        run(16'sd9000, 16'sd0, 16'sd0, exp_cmd(9000, 30), 1'b0);
        run(-16'sd300, 16'sd0, 16'sd0, exp_cmd(-300, 30), 1'b0);
        wr(TSL_ADDR_TQ_GAIN, 32'd100);
        run(16'sd10000, 16'sd0, 16'sd0, exp_cmd(10000, 100), 1'b0);
        wr(TSL_ADDR_TQ_GAIN, 32'd30);
        u_host.drive(16'sd50, 16'sd0, 1'b1);
        repeat (4) @(posedge i_clk);
        wr(TSL_ADDR_CTRL, 32'h1);
        rd(TSL_ADDR_STATUS, 32'h4, "status_refused");
        rd(TSL_ADDR_OFFSET, 32'h0, "offset_kept");
        wr(TSL_ADDR_STATUS, 32'h4);
        rd(TSL_ADDR_STATUS, 32'h0, "status_w1c");
        u_host.drive(16'sd50, 16'sd0, 1'b0);
        repeat (4) @(posedge i_clk);
        wr(TSL_ADDR_CTRL, 32'h1);
        wr(TSL_ADDR_OFFSET, 32'd999);
        rd(TSL_ADDR_STATUS, 32'h1, "status_busy");
        repeat (20) @(posedge i_clk);
        rd(TSL_ADDR_STATUS, 32'h2, "status_done");
        rd(TSL_ADDR_OFFSET, 32'd50, "offset_auto");
        run(16'sd3050, 16'sd0, 16'sd0, exp_cmd(3000, 30), 1'b0);
        wr(TSL_ADDR_OFFSET, 32'hFFFF_FFEC);
        apb(1'b0, TSL_ADDR_OFFSET, 32'h0, d, e);
        chk("offset_manual", 32'hFFFF_FFEC, d);
        run(16'sd3000, 16'sd0, 16'sd0, exp_cmd(3020, 30), 1'b0);
        wr(TSL_ADDR_CTRL, 32'h4);
        run(16'sd3000, 16'sd0, 16'sd1600, 16'sd0, 1'b1);
        rd(TSL_ADDR_STATUS, 32'hA, "status_limiting");
        run(16'sd3000, 16'sd0, 16'sd1400, exp_cmd(3020, 30), 1'b0);
        run(-16'sd3000, 16'sd0, -16'sd1600, 16'sd0, 1'b1);
        run(-16'sd3000, 16'sd0, 16'sd1600, exp_cmd(-2980, 30), 1'b0);
        wr(TSL_ADDR_SPD_LIM, 32'd5000);
        run(16'sd3000, 16'sd0, 16'sd3100, 16'sd0, 1'b1);
        run(16'sd3000, 16'sd0, 16'sd2900, exp_cmd(3020, 30), 1'b0);
        wr(TSL_ADDR_CTRL, 32'h6);
        run(16'sd3000, -16'sd5000, 16'sd800, 16'sd0, 1'b1);
        run(16'sd3000, -16'sd5000, 16'sd700, exp_cmd(3020, 30), 1'b0);
        wr(TSL_ADDR_SPD_GAIN, 32'd300);
        run(16'sd3000, 16'sd2000, 16'sd500, exp_cmd(3020, 30), 1'b0);
        wr(TSL_ADDR_CTRL, 32'h4);
        run(16'sd3000, 16'sd2000, 16'sd3100, 16'sd0, 1'b1);
        summarize();
    end
endmodule
